// ---- verilog/fsp_pkg.sv ----
package fsp_pkg;
	localparam int DR_LEN = 38;
	localparam int IR_LEN = 4;
	localparam logic [3:0] IR_RESET = 4'h1;
	localparam logic [3:0] IR_ENTRY = 4'h2;
	localparam logic [3:0] DR_ENTRY = 4'h2;
	localparam logic [3:0] IR_COMM = 4'hc;
	localparam logic [4:0] ADDR_CTRL = 5'h04;
	localparam logic [4:0] ADDR_DATA = 5'h05;
	localparam int CTRL_RD_AVAIL_BIT = 1;
	localparam int CTRL_WR_PEND_BIT = 0;
	localparam int CNT_SHIFT = 16;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam int CLK_KHZ = 50000;
	localparam int EXT_MIN_KHZ = 32;
	localparam int EXT_MAX_GAP = CLK_KHZ / EXT_MIN_KHZ;
	typedef struct packed {
		logic rw;
		logic [4:0] addr;
		logic [31:0] data;
	} fsp_scan_t;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} fsp_tap_t;
	typedef enum logic [1:0] {
		CMD_HDR, CMD_ADDR, CMD_RUN
	} fsp_cmd_t;
endpackage

// ---- verilog/fsp_fifo.sv ----
module fsp_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [AW:0] cnt, next_cnt;
	logic push, pop;
	assign in_ready = cnt != D[AW:0];
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		next_wp = push ? wp + 1'b1 : wp;
		next_rp = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
		if (sys_rst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
endmodule

// ---- verilog/fsp_port.sv ----
module fsp_port
	import fsp_pkg::*;
#(
	parameter logic [15:0] READ_CODE = 16'h000f,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Test mode straps.
	input wire logic test_mode_select,
	input wire logic program_enable_zero,
	input wire logic program_enable_one,
	// External main clock pin.
	input wire logic main_clock_input,
	// JTAG pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	// Pad and clock control.
	output logic jtag_pullup_en,
	output logic io_pullup_en,
	output logic osc_bypass,
	output logic clk_src_ext,
	// Memory read port.
	output logic mem_rd,
	output logic [31:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	localparam int NP = 7;
	logic [NP-1:0] pin_raw, pin_f, pin_rise, pin_fall;
	logic [2:0] sy [NP];
	assign pin_raw = {main_clock_input, program_enable_one, program_enable_zero, test_mode_select, tdi, tms, tck};

	// A pin change counts only when the second and third stages agree.
	for (genvar i = 0; i < NP; i++) begin : g_sync
		always_ff @(posedge mclk) begin
			sy[i] <= {sy[i][1:0], pin_raw[i]};
			if (sys_rst) begin
				pin_f[i] <= 1'b1;
			end else if (sy[i][1] == sy[i][2]) begin
				pin_f[i] <= sy[i][2];
			end
		end
		assign pin_rise[i] = (sy[i][1] == sy[i][2]) && sy[i][2] && !pin_f[i];
		assign pin_fall[i] = (sy[i][1] == sy[i][2]) && !sy[i][2] && pin_f[i];
	end

	logic tck_rise, tck_fall, tms_f, tdi_f, test_mode, mck_edge;
	assign tck_rise = pin_rise[0];
	assign tck_fall = pin_fall[0];
	assign tms_f = pin_f[1];
	assign tdi_f = pin_f[2];
	assign test_mode = pin_f[3] && pin_f[4] && pin_f[5];
	assign mck_edge = pin_rise[6];

	assign io_pullup_en = test_mode;
	assign osc_bypass = test_mode;
	assign jtag_pullup_en = 1'b1;

	fsp_tap_t tap, next_tap;
	logic [3:0] ir, next_ir, ir_sh, next_ir_sh;
	fsp_scan_t sh, next_sh, rd_buf, next_rd_buf;
	logic entered, next_entered, tdo_q, next_tdo;
	logic comm_sel, enter_upd, upd_wr_data, upd_rd;
	logic wr_pend, next_wr_pend, pend_clr, fifo_pop;
	logic [31:0] host_word, next_host_word;
	logic out_valid, in_ready, fifo_push;
	logic [31:0] out_data;

	assign comm_sel = test_mode && entered && ir == IR_COMM;
	assign enter_upd = tck_rise && tms_f && (tap == EX1_DR || tap == EX2_DR);
	assign upd_wr_data = enter_upd && comm_sel && sh.rw && sh.addr == ADDR_DATA;
	assign upd_rd = enter_upd && comm_sel && !sh.rw;
	assign fifo_pop = upd_rd && sh.addr == ADDR_DATA && out_valid;

	always_comb begin
		next_tap = tap;
		next_ir = ir;
		next_ir_sh = ir_sh;
		next_sh = sh;
		next_rd_buf = rd_buf;
		next_entered = entered;
		next_tdo = tdo_q;
		if (tck_rise) begin
			case (tap)
				TLR: next_tap = tms_f ? TLR : RTI;
				RTI: next_tap = tms_f ? SEL_DR : RTI;
				SEL_DR: next_tap = tms_f ? SEL_IR : CAP_DR;
				CAP_DR: next_tap = tms_f ? EX1_DR : SH_DR;
				SH_DR: next_tap = tms_f ? EX1_DR : SH_DR;
				EX1_DR: next_tap = tms_f ? UPD_DR : PA_DR;
				PA_DR: next_tap = tms_f ? EX2_DR : PA_DR;
				EX2_DR: next_tap = tms_f ? UPD_DR : SH_DR;
				UPD_DR: next_tap = tms_f ? SEL_DR : RTI;
				SEL_IR: next_tap = tms_f ? TLR : CAP_IR;
				CAP_IR: next_tap = tms_f ? EX1_IR : SH_IR;
				SH_IR: next_tap = tms_f ? EX1_IR : SH_IR;
				EX1_IR: next_tap = tms_f ? UPD_IR : PA_IR;
				PA_IR: next_tap = tms_f ? EX2_IR : PA_IR;
				EX2_IR: next_tap = tms_f ? UPD_IR : SH_IR;
				UPD_IR: next_tap = tms_f ? SEL_DR : RTI;
				default: next_tap = TLR;
			endcase
			case (tap)
				TLR: next_ir = IR_RESET;
				CAP_IR: next_ir_sh = 4'h1;
				SH_IR: next_ir_sh = {tdi_f, ir_sh[3:1]};
				CAP_DR: next_sh = comm_sel ? rd_buf : '0;
				SH_DR: next_sh = comm_sel ? {tdi_f, sh[DR_LEN-1:1]} : DR_LEN'({tdi_f, sh[IR_LEN-1:1]});
				default: ;
			endcase
			if (tms_f && (tap == EX1_IR || tap == EX2_IR)) begin
				next_ir = ir_sh;
			end
			if (enter_upd && !comm_sel && ir == IR_ENTRY && sh[3:0] == DR_ENTRY) begin
				next_entered = 1'b1;
			end
			if (enter_upd && sh.rw == 1'b0 && comm_sel) begin
				if (sh.addr == ADDR_CTRL) begin
					next_rd_buf = '0;
					next_rd_buf.data[CTRL_RD_AVAIL_BIT] = out_valid;
					next_rd_buf.data[CTRL_WR_PEND_BIT] = wr_pend;
				end else if (sh.addr == ADDR_DATA) begin
					next_rd_buf = '0;
					next_rd_buf.data = out_valid ? out_data : 32'h0;
				end else begin
					next_rd_buf = '0;
				end
			end
			if (tap == TLR && tms_f) begin
				next_entered = entered && test_mode;
			end
		end
		if (tck_fall) begin
			next_tdo = (tap == SH_IR) ? ir_sh[0] : sh[0];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tap <= TLR;
			ir <= IR_RESET;
			ir_sh <= '0;
			sh <= '0;
			rd_buf <= '0;
			entered <= 1'b0;
			tdo_q <= 1'b0;
		end else begin
			tap <= next_tap;
			ir <= next_ir;
			ir_sh <= next_ir_sh;
			sh <= next_sh;
			rd_buf <= next_rd_buf;
			entered <= next_entered;
			tdo_q <= next_tdo;
		end
	end
	assign tdo = tdo_q;
	assign tdo_oe_n = !(tap == SH_DR || tap == SH_IR);

	// Host word handling; a new write beats a same-cycle consume.
	always_comb begin
		next_host_word = upd_wr_data ? sh.data : host_word;
		next_wr_pend = upd_wr_data ? 1'b1 : (pend_clr ? 1'b0 : wr_pend);
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			host_word <= '0;
			wr_pend <= 1'b0;
		end else begin
			host_word <= next_host_word;
			wr_pend <= next_wr_pend;
		end
	end

	fsp_cmd_t cmd_st, next_cmd_st;
	logic [15:0] remain, next_remain;
	logic [31:0] rd_addr, next_rd_addr;
	assign pend_clr = wr_pend && cmd_st != CMD_RUN;
	// one outstanding fetch, stalled by a full buffer
	assign mem_rd = cmd_st == CMD_RUN && remain != '0 && in_ready;
	assign mem_addr = rd_addr;
	assign fifo_push = mem_rd && mem_ack;

	always_comb begin
		next_cmd_st = cmd_st;
		next_remain = remain;
		next_rd_addr = rd_addr;
		case (cmd_st)
			CMD_HDR: begin
				if (wr_pend && host_word[15:0] == READ_CODE && host_word[31:CNT_SHIFT] != '0) begin
					next_remain = host_word[31:CNT_SHIFT];
					next_cmd_st = CMD_ADDR;
				end
			end
			CMD_ADDR: begin
				if (wr_pend) begin
					next_rd_addr = host_word;
					next_cmd_st = host_word[1:0] == 2'b00 ? CMD_RUN : CMD_HDR;
				end
			end
			CMD_RUN: begin
				if (fifo_push) begin
					next_rd_addr = rd_addr + ADDR_STEP;
					next_remain = remain - 16'h0001;
				end
				if (remain == '0 && !out_valid) begin
					next_cmd_st = CMD_HDR;
				end
			end
			default: next_cmd_st = CMD_HDR;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmd_st <= CMD_HDR;
			remain <= '0;
			rd_addr <= '0;
		end else begin
			cmd_st <= next_cmd_st;
			remain <= next_remain;
			rd_addr <= next_rd_addr;
		end
	end

	fsp_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(fifo_push),
		.in_ready(in_ready),
		.in_data(mem_rdata),
		.out_valid(out_valid),
		.out_ready(fifo_pop),
		.out_data(out_data)
	);

	// Clock source: the choice freezes at the first data register write after entry, so a late clock cannot glitch it.
	logic [10:0] gap, next_gap;
	logic seen, next_seen, ext, next_ext, frozen, next_frozen;
	always_comb begin
		next_gap = (mck_edge || gap == EXT_MAX_GAP[10:0]) ? 11'h000 : gap + 11'h001;
		next_seen = mck_edge ? 1'b1 : (gap == EXT_MAX_GAP[10:0] ? 1'b0 : seen);
		next_frozen = frozen || upd_wr_data;
		next_ext = ext;
		if (!frozen && mck_edge && seen) begin
			next_ext = 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			gap <= '0;
			seen <= 1'b0;
			ext <= 1'b0;
			frozen <= 1'b0;
		end else begin
			gap <= next_gap;
			seen <= next_seen;
			ext <= next_ext;
			frozen <= next_frozen;
		end
	end
	assign clk_src_ext = ext;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_tap_reset_walk: assert property (tck_rise && tms_f && tap == SEL_IR |=> tap == TLR)
		else $error("TAP did not reach reset");
	a_upd_write_pend: assert property (upd_wr_data |=> wr_pend && host_word == $past(sh.data))
		else $error("data write not stored");
	a_ctrl_read_flags: assert property (upd_rd && sh.addr == ADDR_CTRL
		|=> rd_buf.data == {30'h0, $past(out_valid), $past(wr_pend)})
		else $error("control flags wrong");
	a_ctrl_no_write: assert property (enter_upd && comm_sel && sh.rw && sh.addr == ADDR_CTRL && !wr_pend
		|=> !wr_pend)
		else $error("control write had effect");
	a_data_read_word: assert property (fifo_pop |=> rd_buf.data == $past(out_data))
		else $error("data read wrong");
	a_addr_step_four: assert property (fifo_push |=> rd_addr == $past(rd_addr) + ADDR_STEP)
		else $error("address step wrong");
	a_bad_header_drop: assert property (cmd_st == CMD_HDR && wr_pend && host_word[31:CNT_SHIFT] == 16'h0
		|=> cmd_st == CMD_HDR)
		else $error("zero count accepted");
	a_misalign_drop: assert property (cmd_st == CMD_ADDR && wr_pend && host_word[1:0] != 2'b00
		|=> cmd_st == CMD_HDR)
		else $error("misaligned address accepted");
	a_rc_after_reset: assert property ($fell(sys_rst) |-> !clk_src_ext [*2])
		else $error("not on RC after reset");
	a_tdo_follows: assert property (tck_fall && tap == SH_DR |=> tdo == $past(sh[0]))
		else $error("TDO wrong");
	c_read_started: cover property (cmd_st == CMD_ADDR ##1 cmd_st == CMD_RUN);
	c_fifo_full: cover property (!in_ready && cmd_st == CMD_RUN);
	c_word_read: cover property (fifo_pop);
	c_ext_clock: cover property ($rose(clk_src_ext));
endmodule

// ---- sim/fsp_mem_model.sv ----
module fsp_mem_model (
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Read request and answer.
	input wire logic mem_rd,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// Pacing and transfer count.
	input wire logic slow,
	output int acks
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pace;
	// word wide memory
	// Idle data toggles every cycle, so a sample outside an answer is caught.
	always @(posedge mclk) begin
		if (sys_rst) begin
			pace <= 2'h0;
			mem_ack <= 1'b0;
			acks <= 0;
			mem_rdata <= 32'h0;
		end else begin
			pace <= pace + 2'h1;
			if (mem_rd && mem_ack) begin
				acks <= acks + 1;
			end
			mem_ack <= mem_rd && !mem_ack && (!slow || pace == 2'h3);
			mem_rdata <= (mem_rd && !mem_ack) ? {~mem_addr[15:0], mem_addr[15:0]} : ~mem_rdata;
		end
	end
endmodule

// ---- sim/fsp_port_tb.sv ----
module fsp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsp_pkg::*;
	localparam logic [15:0] RCODE = 16'h0021;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic tck = 1'b1;
	logic tms = 1'b1;
	logic tdi = 1'b1;
	logic main_clock_input = 1'b0;
	logic xclk_en = 1'b0;
	logic [2:0] xdiv = 3'h0;
	logic slow = 1'b0;
	logic tdo, tdo_oe_n, jtag_pullup_en, io_pullup_en, osc_bypass, clk_src_ext, mem_rd, mem_ack;
	logic [31:0] mem_addr, mem_rdata, q;
	int acks;
	int num_errors = 0;
	int comparisons = 0;
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		xdiv <= xdiv + 3'h1;
		main_clock_input <= xclk_en & xdiv[2];
	end
	fsp_port #(.READ_CODE(RCODE), .FIFO_DEPTH(8)) i_fsp_port (.mclk(mclk), .sys_rst(sys_rst),
		.test_mode_select(1'b1), .program_enable_zero(1'b1), .program_enable_one(1'b1),
		.main_clock_input(main_clock_input), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n), .jtag_pullup_en(jtag_pullup_en), .io_pullup_en(io_pullup_en),
		.osc_bypass(osc_bypass), .clk_src_ext(clk_src_ext), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	fsp_mem_model i_fsp_mem_model (.mclk(mclk), .sys_rst(sys_rst), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow), .acks(acks));
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {~a[15:0], a[15:0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One link clock period of 160 ns; tdo is taken late in the high phase, well after it settles.
	task automatic jb(input logic m, input logic d, output logic o);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge mclk);
		tck <= 1'b1;
		repeat (4) @(posedge mclk);
		o = tdo;
	endtask
	// Starts and ends in Select-DR, so Run-Test/Idle is never crossed.
	task automatic sh(input logic ir, input int n, input logic [37:0] d, output logic [37:0] r);
		logic o;
		if (ir) jb(1'b1, 1'b0, o);
		jb(1'b0, 1'b0, o);
		jb(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			jb(i == n - 1, d[i], o);
			r[i] = o;
			if (i == 0) chk(32'(tdo_oe_n), 32'h0);
		end
		jb(1'b1, 1'b0, o);
		jb(1'b1, 1'b0, o);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		logic [37:0] r;
		sh(1'b0, DR_LEN, {1'b1, a, v}, r);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		logic [37:0] r;
		sh(1'b0, DR_LEN, {1'b0, a, 32'h0}, r);
		sh(1'b0, DR_LEN, {1'b0, ADDR_CTRL, 32'h0}, r);
		v = r[31:0];
	endtask
	task automatic poll(input int b, input logic want);
		logic [31:0] v;
		for (int k = 0; k < 40; k++) begin
			rd(ADDR_CTRL, v);
			if (v[b] === want) return;
		end
		num_errors++;
		$display("wrong value at %0t ns: flag never settled", $time);
	endtask
	task automatic t_reset();
		chk({29'h0, jtag_pullup_en, tdo_oe_n, mem_rd}, 32'h6);
		chk({30'h0, io_pullup_en, osc_bypass}, 32'h3);
		repeat (2000) @(posedge mclk);
		chk(32'(clk_src_ext), 32'h0);
	endtask
	task automatic t_entry();
		logic [37:0] r;
		logic o;
		xclk_en <= 1'b1;
		repeat (5) jb(1'b1, 1'b0, o);
		jb(1'b0, 1'b0, o);
		jb(1'b1, 1'b0, o);
		sh(1'b1, IR_LEN, 38'(IR_ENTRY), r);
		sh(1'b0, 4, 38'(DR_ENTRY), r);
		sh(1'b1, IR_LEN, 38'(IR_COMM), r);
		chk(32'(clk_src_ext), 32'h1);
		rd(ADDR_CTRL, q);
		chk(q, 32'h0);
	endtask
	task automatic t_ctrl_ro();
		wr(ADDR_CTRL, 32'hffff_ffff);
		rd(ADDR_CTRL, q);
		chk(q, 32'h0);
		rd(ADDR_DATA, q);
		chk(q, 32'h0);
	endtask
	task automatic t_run(input int n, input logic [31:0] a, input logic s);
		int a0;
		int a1;
		a0 = acks;
		slow <= s;
		poll(CTRL_WR_PEND_BIT, 1'b0);
		wr(ADDR_DATA, (32'(n) << CNT_SHIFT) | 32'(RCODE));
		poll(CTRL_WR_PEND_BIT, 1'b0);
		wr(ADDR_DATA, a);
		poll(CTRL_WR_PEND_BIT, 1'b0);
		wr(ADDR_DATA, 32'h0);
		rd(ADDR_CTRL, q);
		chk(q & 32'h3, 32'h3);
		a1 = acks;
		repeat (100) @(posedge mclk);
		chk(32'(acks - a1), 32'h0);
		for (int i = 0; i < n; i++) begin
			poll(CTRL_RD_AVAIL_BIT, 1'b1);
			rd(ADDR_DATA, q);
			chk(q, pat(a + 32'(4 * i)));
		end
		rd(ADDR_CTRL, q);
		chk(q, 32'h0);
		chk(32'(acks - a0), 32'(n));
	endtask
	task automatic t_ignore();
		int a0;
		a0 = acks;
		wr(ADDR_DATA, 32'(RCODE));
		poll(CTRL_WR_PEND_BIT, 1'b0);
		wr(ADDR_DATA, (32'h1 << CNT_SHIFT) | 32'(RCODE));
		poll(CTRL_WR_PEND_BIT, 1'b0);
		wr(ADDR_DATA, 32'h0000_0302);
		repeat (100) @(posedge mclk);
		chk(32'(acks - a0), 32'h0);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge mclk);
		t_reset();
		t_entry();
		t_ctrl_ro();
		t_run(10, 32'h0000_1000, 1'b1);
		t_ignore();
		t_run(2, 32'h0000_0300, 1'b0);
		complete_run();
	end
	initial begin
		repeat (95000) @(posedge mclk);
		num_errors++;
		$display("wrong value at %0t ns: watchdog expired", $time);
		complete_run();
	end
endmodule
